// ### hw/dbio_top.sv
`timescale 1ns/10ps
module dbio_top (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        alt_base_sel,
  input  wire logic [9:0]  io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rd_ack,
  input  wire logic [15:0] line_in,
  output logic      [15:0] line_out,
  output logic      [15:0] line_oe_n
);

  // ****************************************
  // Declarations
  // ****************************************
  logic       alt_sync1_ff;
  logic       alt_ff;
  logic       low_dir_ff;
  logic       high_dir_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       rd_ack_ff;
  logic       hit_ctrl;
  logic       hit_low;
  logic       hit_high;
  logic [9:0] ctrl_addr;
  logic [9:0] low_addr;
  logic [9:0] high_addr;
  logic [7:0] ctrl_value;

  // Next values and strobes
  logic       nxt_low_dir;
  logic       nxt_high_dir;
  logic       nxt_rd_ack;
  logic       ctrl_wr;
  logic       low_wr;
  logic       high_wr;
  logic       map_hit;

  // ****************************************
  // Port carriers
  // ****************************************
  dbio_port_if low_if ();
  dbio_port_if high_if ();

  // ****************************************
  // Base synchroniser
  // ****************************************
  // Setup strap is static, but it comes from off this clock
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      alt_sync1_ff <= dbio_pkg::ALT_RST;
      alt_ff       <= dbio_pkg::ALT_RST;
    end else begin
      alt_sync1_ff <= alt_base_sel;
      alt_ff       <= alt_sync1_ff;
    end
  end

  // ****************************************
  // Base select
  // ****************************************
  // A strap change lands two clocks late; avoid it mid-access
  always_comb begin
    if (alt_ff) begin
      ctrl_addr = dbio_pkg::ALT_CTRL_ADDR;
      low_addr  = dbio_pkg::ALT_LOW_ADDR;
      high_addr = dbio_pkg::ALT_HIGH_ADDR;
    end else begin
      ctrl_addr = dbio_pkg::STD_CTRL_ADDR;
      low_addr  = dbio_pkg::STD_LOW_ADDR;
      high_addr = dbio_pkg::STD_HIGH_ADDR;
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  // Full ten-bit match, so no aliases elsewhere in I/O space
  always_comb begin
    hit_ctrl = (io_addr == ctrl_addr);
    hit_low  = (io_addr == low_addr);
    hit_high = (io_addr == high_addr);
    map_hit  = hit_ctrl || hit_low || hit_high;
  end

  // ****************************************
  // Write strobes
  // ****************************************
  // Unmapped writes raise no strobe and change nothing
  assign ctrl_wr = io_wr && hit_ctrl;
  assign low_wr  = io_wr && hit_low;
  assign high_wr = io_wr && hit_high;

  // ****************************************
  // Direction control
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      low_dir_ff  <= dbio_pkg::DIR_RST;
      high_dir_ff <= dbio_pkg::DIR_RST;
    end else begin
      low_dir_ff  <= nxt_low_dir;
      high_dir_ff <= nxt_high_dir;
    end
  end

  // Pins follow one clock after the bit, as the drive enable is registered
  always_comb begin
    nxt_low_dir  = low_dir_ff;
    nxt_high_dir = high_dir_ff;
    if (ctrl_wr) begin
      nxt_low_dir  = io_wdata[dbio_pkg::LOW_DIR_BIT];
      nxt_high_dir = io_wdata[dbio_pkg::HIGH_DIR_BIT];
    end
  end

  // ****************************************
  // Control readback
  // ****************************************
  // Analog status bits live elsewhere and read as zero here
  always_comb begin
    ctrl_value                          = 8'h00;
    ctrl_value[dbio_pkg::LOW_DIR_BIT]  = low_dir_ff;
    ctrl_value[dbio_pkg::HIGH_DIR_BIT] = high_dir_ff;
  end

  // ****************************************
  // Port wiring
  // ****************************************
  // Both ports share the write data; only the strobe and the direction bit differ
  assign low_if.wr_stb   = low_wr;
  assign low_if.wr_data  = io_wdata;
  assign low_if.dir_out  = low_dir_ff;

  assign high_if.wr_stb  = high_wr;
  assign high_if.wr_data = io_wdata;
  assign high_if.dir_out = high_dir_ff;

  // ****************************************
  // Port slices
  // ****************************************
  // Bit n of each register maps to line n of its port
  dbio_port_slice u_low (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .bus      (low_if.port),
    .pin_in   (line_in[7:0]),
    .pin_out  (line_out[7:0]),
    .pin_oe_n (line_oe_n[7:0])
  );

  dbio_port_slice u_high (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .bus      (high_if.port),
    .pin_in   (line_in[15:8]),
    .pin_out  (line_out[15:8]),
    .pin_oe_n (line_oe_n[15:8])
  );

  // ****************************************
  // Read path
  // ****************************************
  // Unmapped addresses read zero so a stray read is harmless
  always_comb begin
    nxt_rdata = 8'h00;
    if (hit_low) begin
      nxt_rdata = low_if.rd_value;
    end else if (hit_high) begin
      nxt_rdata = high_if.rd_value;
    end else if (hit_ctrl) begin
      nxt_rdata = ctrl_value;
    end
  end

  // Unmapped reads get no ack, leaving the bus to others
  assign nxt_rd_ack = io_rd && map_hit;

  // Ack rises one clock after a mapped read and stays high for as long as io_rd is held
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_ack_ff <= dbio_pkg::ACK_RST;
    end else begin
      rd_ack_ff <= nxt_rd_ack;
    end
  end

  // Data holds until the next read, so a late master still sees it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_ff <= dbio_pkg::RDATA_RST;
    end else if (io_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign io_rdata  = rdata_ff;
  assign io_rd_ack = rd_ack_ff;

endmodule

// ### common/dbio_pkg.sv
package dbio_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W     = 10;
  localparam int DATA_W     = 8;
  localparam int PORT_LINES = 8;

  // ****************************************
  // I/O addresses, standard and alternate base
  // ****************************************
  localparam logic [9:0] STD_CTRL_ADDR = 10'h0E2;
  localparam logic [9:0] STD_LOW_ADDR  = 10'h0E6;
  localparam logic [9:0] STD_HIGH_ADDR = 10'h0E7;
  localparam logic [9:0] ALT_CTRL_ADDR = 10'h1E2;
  localparam logic [9:0] ALT_LOW_ADDR  = 10'h1E6;
  localparam logic [9:0] ALT_HIGH_ADDR = 10'h1E7;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int LOW_DIR_BIT  = 0;
  localparam int HIGH_DIR_BIT = 1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic       DIR_RST   = 1'h0;
  localparam logic       ACK_RST   = 1'h0;
  localparam logic       ALT_RST   = 1'h0;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [7:0] OE_N_RST  = 8'hFF;
  localparam logic [7:0] LINE_RST  = 8'h00;

endpackage

// ### common/dbio_port_if.sv
`timescale 1ns/10ps
interface dbio_port_if;
  logic       wr_stb;
  logic [7:0] wr_data;
  logic       dir_out;
  logic [7:0] rd_value;

  modport ctl  (output wr_stb, output wr_data, output dir_out, input rd_value);
  modport port (input wr_stb, input wr_data, input dir_out, output rd_value);
endinterface

// ### hw/dbio_port_slice.sv
`timescale 1ns/10ps
module dbio_port_slice (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  dbio_port_if.port       bus,
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe_n
);

  logic [7:0] latch_ff;
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  logic [7:0] oe_n_ff;

  // ****************************************
  // Output latch
  // ****************************************
  // Latch loads even in input mode, so output starts clean
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      latch_ff <= dbio_pkg::LATCH_RST;
    end else if (bus.wr_stb) begin
      latch_ff <= bus.wr_data;
    end
  end

  // ****************************************
  // Drive enable
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      oe_n_ff <= dbio_pkg::OE_N_RST;
    end else begin
      oe_n_ff <= {8{~bus.dir_out}};
    end
  end

  // ****************************************
  // Pin synchroniser
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync1_ff <= dbio_pkg::LINE_RST;
      sync2_ff <= dbio_pkg::LINE_RST;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  assign pin_out  = latch_ff;
  assign pin_oe_n = oe_n_ff;

  // Output mode reads the latch back, not the pins
  assign bus.rd_value = bus.dir_out ? latch_ff : sync2_ff;

endmodule

// ### sim/dbio_far_side.sv
`timescale 1ns/10ps
module dbio_far_side (
  input  wire logic [15:0] ext_val,
  input  wire logic [15:0] line_out,
  input  wire logic [15:0] line_oe_n,
  output logic      [15:0] line_in
);
  // Wire level: device wins where it drives, else the far side
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      line_in[i] = line_oe_n[i] ? ext_val[i] : line_out[i];
    end
  end
endmodule

// ### sim/dbio_assertions.sv
`timescale 1ns/10ps
module dbio_assertions (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        alt_base_sel,
  input wire logic [9:0]  io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rd_ack,
  input wire logic [15:0] line_in,
  input wire logic [15:0] line_out,
  input wire logic [15:0] line_oe_n
);
  // Base select must be settled past its synchroniser
  logic [1:0] sel_hist_ff;
  logic       base_std;
  logic       base_alt;
  always_ff @(posedge clk_sys) sel_hist_ff <= {sel_hist_ff[0], alt_base_sel};
  assign base_std = !alt_base_sel && sel_hist_ff == 2'h0;
  assign base_alt = alt_base_sel && sel_hist_ff == 2'h3;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_wr_low;
    base_std && io_wr && io_addr == 10'h0E6;
  endsequence
  sequence s_wr_high;
    base_std && io_wr && io_addr == 10'h0E7;
  endsequence
  sequence s_wr_alt;
    base_alt && io_wr && io_addr == 10'h1E6;
  endsequence
  sequence s_wr_dir;
    base_std && io_wr && io_addr == 10'h0E2;
  endsequence
  a_low_data: assert property (s_wr_low |=> line_out[7:0] == $past(io_wdata))
    else $error("low latch");
  a_high_data: assert property (s_wr_high |=> line_out[15:8] == $past(io_wdata))
    else $error("high latch");
  a_alt_data: assert property (s_wr_alt |=> line_out[7:0] == $past(io_wdata))
    else $error("alt latch");
  a_low_dir: assert property (s_wr_dir |=> ##1 line_oe_n[7:0] == {8{!$past(io_wdata[0], 2)}})
    else $error("low dir");
  a_high_dir: assert property (s_wr_dir |=> ##1 line_oe_n[15:8] == {8{!$past(io_wdata[1], 2)}})
    else $error("high dir");
  a_byte_whole: assert property ((line_oe_n[7:0] inside {8'h00, 8'hFF}) &&
    (line_oe_n[15:8] inside {8'h00, 8'hFF})) else $error("split byte");
  // Direction written one clock earlier is not yet on the drive enable
  a_in_read: assert property (base_std && io_rd && io_addr == 10'h0E6 && line_oe_n[7:0] == 8'hFF &&
    !$past(io_wr && io_addr == 10'h0E2) && $past(line_in[7:0]) == line_in[7:0] &&
    $past(line_in[7:0], 2) == line_in[7:0] |=> io_rd_ack && io_rdata == $past(line_in[7:0]))
    else $error("input read");
  a_no_ack: assert property (io_rd && io_addr == 10'h300 |=> !io_rd_ack && io_rdata == 8'h00)
    else $error("unmapped ack");
  a_reset_idle: assert property (disable iff (1'h0) reset |=> line_oe_n == 16'hFFFF && !io_rd_ack)
    else $error("reset drive");
endmodule
bind dbio_top dbio_assertions dbio_assertions_i (.clk_sys(clk_sys), .reset(reset), .alt_base_sel(alt_base_sel),
  .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .io_rd_ack(io_rd_ack), .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n));

// ### sim/dual_byte_digital_io_port_test.sv
`timescale 1ns/10ps
module dual_byte_digital_io_port_test;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        alt_base_sel = 1'b0;
  logic [9:0]  io_addr = 10'h000;
  logic        io_wr = 1'b0;
  logic        io_rd = 1'b0;
  logic [7:0]  io_wdata = 8'h00;
  logic [7:0]  io_rdata;
  logic        io_rd_ack;
  logic [15:0] line_in, line_out, line_oe_n;
  logic [15:0] ext_val = 16'hA55A;
  int          errors = 0;
  int          checks_done = 0;
  always #50 clk_sys = ~clk_sys;
  dbio_top dbio_top_i (.clk_sys(clk_sys), .reset(reset), .alt_base_sel(alt_base_sel), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_ack(io_rd_ack),
    .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n));
  dbio_far_side dbio_far_side_i (.ext_val(ext_val), .line_out(line_out), .line_oe_n(line_oe_n),
    .line_in(line_in));
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Idle cycle after each strobe so it never re-rises in one step
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    tick(1);
    io_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] d, input logic ack);
    io_addr = a;
    io_rd = 1'b1;
    tick(1);
    io_rd = 1'b0;
    chk({7'h00, io_rd_ack, io_rdata}, {7'h00, ack, d});
    tick(1);
  endtask
  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    tick(8);
    reset = 1'b0;
    chk(line_oe_n, 16'hFFFF);
    tick(2);
    rd(10'h0E6, 8'h5A, 1'b1);
    rd(10'h0E7, 8'hA5, 1'b1);
    wr(10'h0E6, 8'h3C);
    chk(line_oe_n, 16'hFFFF);
    wr(10'h0E2, 8'h01);
    chk(line_oe_n, 16'hFF00);
    chk(line_in, 16'hA53C);
    wr(10'h0E2, 8'h02);
    rd(10'h0E2, 8'h02, 1'h1);
    wr(10'h0E7, 8'hC3);
    chk(line_out, 16'hC33C);
    chk(line_oe_n, 16'h00FF);
    rd(10'h0E7, 8'hC3, 1'b1);
    ext_val = 16'h12C6;
    tick(2);
    rd(10'h0E6, 8'hC6, 1'h1);
    rd(10'h300, 8'h00, 1'b0);
    alt_base_sel = 1'b1;
    tick(3);
    wr(10'h1E6, 8'h81);
    wr(10'h1E2, 8'h03);
    rd(10'h1E2, 8'h03, 1'h1);
    rd(10'h1E6, 8'h81, 1'b1);
    rd(10'h0E6, 8'h00, 1'b0);
    // Second reset with both ports driving
    reset = 1'h1;
    tick(1);
    reset = 1'h0;
    chk(line_oe_n, 16'hFFFF);
    chk(line_out, 16'h0000);
    report_and_stop();
  end
endmodule
